/* src/rtc_match_counter_defines.vh */
// Constants for the real-time match counter: byte map, control fields and timing counts.
`ifndef RTC_MATCH_COUNTER_DEFINES_VH
`define RTC_MATCH_COUNTER_DEFINES_VH

// Byte addresses on the configuration mux, one byte per address.
`define ADDR_CTRL 8'h00
`define ADDR_COUNT_B0 8'h01
`define ADDR_COUNT_B4 8'h05
`define ADDR_MATCH_B0 8'h06
`define ADDR_MATCH_B4 8'h0a
`define ADDR_MBITS_B0 8'h0b
`define ADDR_MBITS_B4 8'h0f

// Control/status register fields.
`define CTRL_RESET_VALUE 8'h00
`define BIT_BLOCK_RST 7
`define BIT_COUNT_EN 6
`define BIT_REG_ON_MATCH 5
`define FIELD_XTAL_MODE_HI 4
`define FIELD_XTAL_MODE_LO 3
`define BIT_CLR_ON_MATCH 2
`define BIT_COUNT_RST_N 1
`define BIT_XTAL_EN 0

// Counter and prescaler figures.
`define COUNT_WIDTH 40
`define COUNT_ZERO 40'h0000000000
`define PRESCALE_DIVIDE 128
`define PRESCALE_WIDTH 7
`define PRESCALE_START 7'h40
`define PRESCALE_LAST 7'h7f
`define RELEASE_CYCLES 2
`define RELEASE_LAST 2'd1

`endif

/* src/rtc_prescaler.v */
// Divide-by-128 prescaler on the rising edges of the sampled counter clock.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_match_counter_defines.vh"

module rtc_prescaler (
    input wire clock_in,
    input wire srst_in,
    input wire run_in,
    input wire counter_clock_in,
    output reg tick_out
);

    reg counter_clock_prev;
    reg [`PRESCALE_WIDTH-1:0] prescale;
    wire clock_rise;

    assign clock_rise = counter_clock_in & ~counter_clock_prev;

    always @(posedge clock_in) begin
        if (srst_in) begin
            counter_clock_prev <= 1'b0;
            prescale <= `PRESCALE_START;
            tick_out <= 1'b0;
        end else begin
            counter_clock_prev <= counter_clock_in;
            tick_out <= 1'b0;
            // Stopping returns to the start point, so the first tick comes 64 edges after a start.
            if (!run_in) begin
                prescale <= `PRESCALE_START;
            end else if (clock_rise) begin
                prescale <= prescale + 7'h01;
                if (prescale == `PRESCALE_LAST) begin
                    tick_out <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* src/rtc_match_counter.v */
// Real-time match counter with its byte-wide configuration port and oscillator controls.
// What this block does
// - Keeps a loadable 40-bit up-counter as the time base.
// - Divides the counter clock by 128 and counts only on prescaled ticks.
// - Every configuration address holds one byte; wide values span several bytes.
// - Counter bytes can be preloaded and read back at the same addresses.
// - Count byte 0 reads the live count; the upper count bytes come from a hold register loaded with the whole count on each byte 0 read.
// - Match-bits bytes read all ones while the count equals the match value.
// - Clear-on-match zeroes the count on equality, unless the match value is zero.
// - Clear-on-match is control bit 2 and acts on a prescaled tick.
// - Control bit 7 resets the block; release follows two cycles after writing 0.
// - Count enable bit 6 needs reset released; first increment after 64 edges.
// - Disabling stops the prescaler, keeps the count; loads only while disabled.
// - Regulator-on-match bit 5 gates both match outputs; zero holds them low.
// - Power-sequencer match output equals the fabric match output.
// - Bits 4:3 drive the crystal mode output directly.
// - Bit 1 low holds the 40-bit count at zero.
// - Bit 0 drives the crystal select output.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_match_counter_defines.vh"

module rtc_match_counter (
    input wire clock_in,
    input wire srst_in,
    input wire counter_clock_in,
    input wire [7:0] cfg_addr_in,
    input wire [7:0] cfg_wdata_in,
    input wire cfg_wen_in,
    input wire cfg_ren_in,
    output reg [7:0] cfg_rdata_out,
    output reg [1:0] crystal_mode_out,
    output reg crystal_select_out,
    output reg fabric_match_out,
    output reg power_seq_match_out
);

    // Control/status register and the block reset release stage.
    reg [7:0] rtc_control_status;
    reg block_rst;
    reg [1:0] release_count;

    // Time base, match value and read-hold copy.
    reg [`COUNT_WIDTH-1:0] count;
    reg [`COUNT_WIDTH-1:0] match_value;
    reg [`COUNT_WIDTH-1:0] read_hold;
    reg [`COUNT_WIDTH-1:0] next_count;
    reg [7:0] next_rdata;
    reg [`COUNT_WIDTH-1:0] next_match_value;
    reg [`COUNT_WIDTH-1:0] next_read_hold;
    reg [7:0] next_control;
    reg next_block_rst;
    reg [1:0] next_release_count;
    reg next_fabric_match;
    reg [1:0] next_crystal_mode;
    reg next_crystal_select;

    wire prescale_tick;
    wire prescale_run;
    wire count_equal;
    wire match_nonzero;
    wire clear_on_match;
    wire count_rst_n;
    wire counting;
    wire is_count_byte;
    wire is_match_byte;
    wire is_mbits_byte;

    assign count_equal = (count == match_value);
    assign match_nonzero = (match_value != `COUNT_ZERO);
    assign clear_on_match = rtc_control_status[`BIT_CLR_ON_MATCH];
    assign count_rst_n = rtc_control_status[`BIT_COUNT_RST_N];
    assign counting = rtc_control_status[`BIT_COUNT_EN];
    assign prescale_run = counting & ~block_rst;

    // Byte range decode of the multi-byte fields.
    assign is_count_byte = (cfg_addr_in >= `ADDR_COUNT_B0) && (cfg_addr_in <= `ADDR_COUNT_B4);
    assign is_match_byte = (cfg_addr_in >= `ADDR_MATCH_B0) && (cfg_addr_in <= `ADDR_MATCH_B4);
    assign is_mbits_byte = (cfg_addr_in >= `ADDR_MBITS_B0) && (cfg_addr_in <= `ADDR_MBITS_B4);

    rtc_prescaler u_prescaler (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .run_in(prescale_run),
        .counter_clock_in(counter_clock_in),
        .tick_out(prescale_tick)
    );

    // Control/status register takes a whole byte on a write to its address.
    always @* begin
        next_control = rtc_control_status;
        if (cfg_wen_in && (cfg_addr_in == `ADDR_CTRL)) begin
            next_control = cfg_wdata_in;
        end
    end

    always @(posedge clock_in) begin
        if (srst_in) begin
            rtc_control_status <= `CTRL_RESET_VALUE;
        end else begin
            rtc_control_status <= next_control;
        end
    end

    // Block reset holds while bit 7 is set and lifts two cycles after it is cleared.
    always @* begin
        next_block_rst = block_rst;
        next_release_count = release_count;
        if (rtc_control_status[`BIT_BLOCK_RST]) begin
            next_block_rst = 1'b1;
            next_release_count = 2'd0;
        end else if (block_rst) begin
            next_release_count = release_count + 2'd1;
            if (release_count == `RELEASE_LAST) begin
                next_block_rst = 1'b0;
            end
        end
    end

    always @(posedge clock_in) begin
        if (srst_in) begin
            block_rst <= 1'b1;
            release_count <= 2'd0;
        end else begin
            block_rst <= next_block_rst;
            release_count <= next_release_count;
        end
    end

    // Next count: reset, hold, load, or advance on a prescaled tick.
    always @* begin
        next_count = count;
        if (block_rst || !count_rst_n) begin
            next_count = `COUNT_ZERO;
        end else if (!counting) begin
            if (cfg_wen_in && is_count_byte) begin
                if (cfg_addr_in == `ADDR_COUNT_B0) begin
                    next_count[7:0] = cfg_wdata_in;
                end else if (cfg_addr_in == `ADDR_COUNT_B0 + 8'h01) begin
                    next_count[15:8] = cfg_wdata_in;
                end else if (cfg_addr_in == `ADDR_COUNT_B0 + 8'h02) begin
                    next_count[23:16] = cfg_wdata_in;
                end else if (cfg_addr_in == `ADDR_COUNT_B0 + 8'h03) begin
                    next_count[31:24] = cfg_wdata_in;
                end else begin
                    next_count[39:32] = cfg_wdata_in;
                end
            end
        end else if (prescale_tick) begin
            if (clear_on_match && match_nonzero && count_equal) begin
                next_count = `COUNT_ZERO;
            end else begin
                next_count = count + 40'h0000000001;
            end
        end
    end

    always @(posedge clock_in) begin
        if (srst_in) begin
            count <= `COUNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // Match value bytes, cleared while the block is held in reset.
    always @* begin
        next_match_value = match_value;
        if (block_rst) begin
            next_match_value = `COUNT_ZERO;
        end else if (cfg_wen_in && is_match_byte) begin
            if (cfg_addr_in == `ADDR_MATCH_B0) begin
                next_match_value[7:0] = cfg_wdata_in;
            end else if (cfg_addr_in == `ADDR_MATCH_B0 + 8'h01) begin
                next_match_value[15:8] = cfg_wdata_in;
            end else if (cfg_addr_in == `ADDR_MATCH_B0 + 8'h02) begin
                next_match_value[23:16] = cfg_wdata_in;
            end else if (cfg_addr_in == `ADDR_MATCH_B0 + 8'h03) begin
                next_match_value[31:24] = cfg_wdata_in;
            end else begin
                next_match_value[39:32] = cfg_wdata_in;
            end
        end
    end

    always @(posedge clock_in) begin
        if (srst_in) begin
            match_value <= `COUNT_ZERO;
        end else begin
            match_value <= next_match_value;
        end
    end

    // Reading the lowest count byte freezes the whole count for the other bytes.
    always @* begin
        next_read_hold = read_hold;
        if (cfg_ren_in && (cfg_addr_in == `ADDR_COUNT_B0)) begin
            next_read_hold = count;
        end
    end

    always @(posedge clock_in) begin
        if (srst_in) begin
            read_hold <= `COUNT_ZERO;
        end else begin
            read_hold <= next_read_hold;
        end
    end

    // Read data selection.
    always @* begin
        next_rdata = 8'h00;
        if (cfg_addr_in == `ADDR_CTRL) begin
            next_rdata = rtc_control_status;
        end else if (cfg_addr_in == `ADDR_COUNT_B0) begin
            next_rdata = count[7:0];
        end else if (cfg_addr_in == `ADDR_COUNT_B0 + 8'h01) begin
            next_rdata = read_hold[15:8];
        end else if (cfg_addr_in == `ADDR_COUNT_B0 + 8'h02) begin
            next_rdata = read_hold[23:16];
        end else if (cfg_addr_in == `ADDR_COUNT_B0 + 8'h03) begin
            next_rdata = read_hold[31:24];
        end else if (cfg_addr_in == `ADDR_COUNT_B4) begin
            next_rdata = read_hold[39:32];
        end else if (cfg_addr_in == `ADDR_MATCH_B0) begin
            next_rdata = match_value[7:0];
        end else if (cfg_addr_in == `ADDR_MATCH_B0 + 8'h01) begin
            next_rdata = match_value[15:8];
        end else if (cfg_addr_in == `ADDR_MATCH_B0 + 8'h02) begin
            next_rdata = match_value[23:16];
        end else if (cfg_addr_in == `ADDR_MATCH_B0 + 8'h03) begin
            next_rdata = match_value[31:24];
        end else if (cfg_addr_in == `ADDR_MATCH_B4) begin
            next_rdata = match_value[39:32];
        end else if (is_mbits_byte) begin
            next_rdata = count_equal ? 8'hff : 8'h00;
        end
    end

    always @(posedge clock_in) begin
        if (srst_in) begin
            cfg_rdata_out <= 8'h00;
        end else if (cfg_ren_in) begin
            cfg_rdata_out <= next_rdata;
        end
    end

    // Match and oscillator control values, registered below.
    always @* begin
        next_fabric_match = count_equal & rtc_control_status[`BIT_REG_ON_MATCH];
        next_crystal_mode = rtc_control_status[`FIELD_XTAL_MODE_HI:`FIELD_XTAL_MODE_LO];
        next_crystal_select = rtc_control_status[`BIT_XTAL_EN];
    end

    // Match and oscillator control outputs.
    always @(posedge clock_in) begin
        if (srst_in) begin
            fabric_match_out <= 1'b0;
            power_seq_match_out <= 1'b0;
            crystal_mode_out <= 2'b00;
            crystal_select_out <= 1'b0;
        end else begin
            fabric_match_out <= next_fabric_match;
            power_seq_match_out <= next_fabric_match;
            crystal_mode_out <= next_crystal_mode;
            crystal_select_out <= next_crystal_select;
        end
    end

endmodule
`default_nettype wire

/* sim/rtc_match_counter_assertions.sv */
// Port-level assertions for the real-time match counter.
`timescale 1ns/100ps
`default_nettype none
module rtc_match_counter_checker (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic counter_clock_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic cfg_wen_in,
    input wire logic cfg_ren_in,
    input wire logic [7:0] cfg_rdata_out,
    input wire logic [1:0] crystal_mode_out,
    input wire logic crystal_select_out,
    input wire logic fabric_match_out,
    input wire logic power_seq_match_out
);
    logic [7:0] ctrl;
    always @(posedge clock_in) begin
        if (srst_in) ctrl <= 8'h00;
        else if (cfg_wen_in && cfg_addr_in == 8'h00) ctrl <= cfg_wdata_in;
    end
    default clocking dc @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_ctrl_wr;
        cfg_wen_in && cfg_addr_in == 8'h00;
    endsequence
    sequence s_ctrl_rd;
        cfg_ren_in && cfg_addr_in == 8'h00;
    endsequence
    property p_readback;
        s_ctrl_wr ##1 s_ctrl_rd |=> cfg_rdata_out == $past(cfg_wdata_in, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("control readback wrong");
    property p_mode; $stable(ctrl) |-> crystal_mode_out == ctrl[4:3]; endproperty
    a_mode: assert property (p_mode) else $error("crystal mode wrong");
    property p_select; $stable(ctrl) |-> crystal_select_out == ctrl[0]; endproperty
    a_select: assert property (p_select) else $error("crystal select wrong");
    property p_gate; !ctrl[5] && !$past(ctrl[5]) |-> !fabric_match_out; endproperty
    a_gate: assert property (p_gate) else $error("match not gated");
    property p_twin; fabric_match_out == power_seq_match_out; endproperty
    a_twin: assert property (p_twin) else $error("match outputs differ");
    property p_mbits;
        cfg_ren_in && cfg_addr_in inside {[8'h0b:8'h0f]} |=> cfg_rdata_out inside {8'h00, 8'hff};
    endproperty
    a_mbits: assert property (p_mbits) else $error("match bits byte wrong");
    property p_count_rst;
        cfg_ren_in && cfg_addr_in == 8'h01 && !ctrl[1] && !$past(ctrl[1]) && !$past(ctrl[1], 2)
        |=> cfg_rdata_out == 8'h00;
    endproperty
    a_count_rst: assert property (p_count_rst) else $error("count not held");
    property p_blk_rst;
        cfg_ren_in && cfg_addr_in inside {[8'h06:8'h0a]} && ctrl[7] && $past(ctrl[7])
        && $past(ctrl[7], 2) |=> cfg_rdata_out == 8'h00;
    endproperty
    a_blk_rst: assert property (p_blk_rst) else $error("match not cleared");
endmodule
bind rtc_match_counter rtc_match_counter_checker u_rtc_match_counter_checker (.clock_in,
    .srst_in, .counter_clock_in, .cfg_addr_in, .cfg_wdata_in, .cfg_wen_in, .cfg_ren_in,
    .cfg_rdata_out, .crystal_mode_out, .crystal_select_out, .fabric_match_out,
    .power_seq_match_out);
`default_nettype wire

/* sim/xtal_osc_model.sv */
// Free-running crystal oscillator model feeding the counter clock.
`timescale 1ns/100ps
`default_nettype none
module xtal_osc_model #(parameter int TAP = 1) (
    input wire logic clock_in,
    output wire logic osc_clock_out
);
    logic [3:0] cnt = 4'h0;
    always @(posedge clock_in) cnt <= cnt + 4'h1;
    assign osc_clock_out = cnt[TAP];
endmodule
`default_nettype wire

/* sim/rtc_match_counter_bench.sv */
// Self-checking bench for the real-time match counter.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module rtc_match_counter_bench;
    logic clock_in = 1'b0, srst_in = 1'b1, cfg_wen_in = 1'b0, cfg_ren_in = 1'b0, rd_seen = 1'b0;
    logic [7:0] cfg_addr_in = 8'h00, cfg_wdata_in = 8'h00, d, e;
    logic [39:0] p;
    logic [7:0] exp_q[$];
    int n_errors = 0, n_checks = 0;
    wire logic counter_clock_in, crystal_select_out, fabric_match_out, power_seq_match_out;
    wire logic [7:0] cfg_rdata_out;
    wire logic [1:0] crystal_mode_out;
    always #4 clock_in = ~clock_in;
    xtal_osc_model u_xtal_osc_model (.clock_in, .osc_clock_out(counter_clock_in));
    rtc_match_counter u_rtc_match_counter (.clock_in, .srst_in, .counter_clock_in,
        .cfg_addr_in, .cfg_wdata_in, .cfg_wen_in, .cfg_ren_in, .cfg_rdata_out,
        .crystal_mode_out, .crystal_select_out, .fabric_match_out, .power_seq_match_out);
    always @(posedge clock_in) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("rdata", e, cfg_rdata_out)
        end
        rd_seen <= cfg_ren_in;
    end
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] v);
        @(negedge clock_in);
        cfg_addr_in = a;
        cfg_wdata_in = v;
        cfg_wen_in = (k == 1);
        cfg_ren_in = (k == 2);
        if (k == 2) exp_q.push_back(v);
    endtask
    task automatic op5(input int k, input logic [7:0] a, input logic [39:0] v);
        for (int i = 0; i < 5; i++) op(k, a + 8'(i), v[8*i +: 8]);
    endtask
    task automatic idle(input int n);
        op(0, 8'h00, 8'h00);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic wait_match;
        for (int k = 0; k < 3000 && fabric_match_out !== 1'b1; k++) @(negedge clock_in);
        `CHK("match", 1'b1, fabric_match_out)
        `CHK("psm", 1'b1, power_seq_match_out)
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        final_report;
    end
    initial begin
        void'($urandom(49155));
        p = {8'($urandom), $urandom};
        p[7:0] = 8'hff;
        repeat (2) @(negedge clock_in);
        srst_in = 1'b0;
        idle(3);
        op(2, 8'h00, 8'h00);
        op(2, 8'h20, 8'h00);
        for (int m = 0; m < 4; m++) begin
            d = {3'b000, 2'(m), 2'b00, m[0]};
            op(1, 8'h00, d);
            op(2, 8'h00, d);
            idle(2);
            `CHK("mode", 2'(m), crystal_mode_out)
            `CHK("sel", m[0], crystal_select_out)
        end
        op(2, 8'h01, 8'h00);
        op(1, 8'h00, 8'h82);
        op5(1, 8'h06, p);
        op(2, 8'h06, 8'h00);
        op(1, 8'h00, 8'h02);
        idle(3);
        op5(1, 8'h01, p);
        op5(2, 8'h01, p);
        op(1, 8'h00, 8'h42);
        idle(220);
        op(2, 8'h01, 8'hff);
        idle(70);
        op(2, 8'h02, p[15:8]);
        p = p + 40'h1;
        op(2, 8'h01, p[7:0]);
        op(2, 8'h02, p[15:8]);
        op(1, 8'h01, 8'h5a);
        idle(400);
        op(2, 8'h01, 8'h00);
        op(1, 8'h00, 8'h26);
        op5(1, 8'h01, 40'hffffffffff);
        op5(1, 8'h06, 40'h0000000000);
        op(1, 8'h00, 8'h66);
        wait_match;
        op(2, 8'h0b, 8'hff);
        op(2, 8'h01, 8'h00);
        op(1, 8'h00, 8'h46);
        idle(2);
        `CHK("gate", 1'b0, fabric_match_out)
        op(2, 8'h0f, 8'hff);
        idle(560);
        op(2, 8'h01, 8'h01);
        op(1, 8'h00, 8'h27);
        op5(1, 8'h01, 40'h0000000000);
        op5(1, 8'h06, 40'h0000000002);
        op(1, 8'h00, 8'h67);
        wait_match;
        idle(560);
        op(2, 8'h01, 8'h00);
        idle(2);
        final_report;
    end
endmodule
`default_nettype wire
